// >>> verilog/cmc_mode_control.v
// mode and handshake control of the can controller: control registers,
// sleep and init handshakes, tx pin protection and init-mode write locks.
// assumes bit_tick_in pulses once per nominal bit from the bit timing logic
// and that bus_idle_in / busoff_in come from the protocol engine on clk_sys_in.
//
// How it works
// - stop or disabled-wait forces tx pin recessive
// - init request forces tx pin recessive at once
// - sleep request clear ignored until sleep entered
// - init request clear ignored until init entered
// - init keeps wake enable and both requests
// - tx and rx state fields unaffected by init
// - second control register writable only in init
// - module enable write-once normally, repeatable special
// - bit 7 enables the module
// - bit 6 selects bus clock over oscillator
// - bit 5 loops transmitter back to receiver
// - listen-only receives, never acks nor transmits
// - listen-only freezes both error counters
// - bit 3 selects automatic or requested busoff recovery
// - bit 2 selects filtered dominant wake-up
// - sleep ack set on entry, cleared with request
// - armed wake-up in sleep clears sleep ack
// - bit 0 acknowledges init, active when both set
// - timing, filter registers writable only in init
// - sleep entered only while bus idle
// - resync after 11 recessive, busoff 128 runs
// - wake only if enabled before sleep entry
`timescale 1ns/10ps
`include "cmc_map.vh"
`default_nettype none

module cmc_mode_control #(
	parameter integer WAKE_FILTER_NS = `CMC_WAKE_FILTER_NS,
	parameter integer FILTER_REGS    = 8
) (
	// clock and reset
	input  wire       clk_sys_in,
	input  wire       rst_n_in,
	// register port
	input  wire [4:0] reg_addr_in,
	input  wire [7:0] reg_wdata_in,
	input  wire       reg_wr_in,
	input  wire       reg_rd_in,
	output reg  [7:0] reg_rdata_out,
	// system state
	input  wire       cpu_stop_in,
	input  wire       cpu_wait_in,
	input  wire       special_mode_in,
	// protocol engine
	input  wire       bus_idle_in,
	input  wire       busoff_in,
	input  wire       busoff_user_req_in,
	input  wire       bit_tick_in,
	input  wire       core_tx_in,
	input  wire       core_ack_in,
	input  wire [1:0] tx_state_field_in,
	input  wire [1:0] rx_state_field_in,
	output wire       core_rx_out,
	output reg        busoff_recovered_out,
	// configuration to the rest of the controller
	output wire       module_enable_out,
	output wire       clock_select_out,
	output wire       listen_only_out,
	output wire       err_count_freeze_out,
	output wire       busoff_recovery_select_out,
	output wire       init_mode_out,
	output wire       sleep_mode_out,
	output wire       timer_enable_out,
	output wire [7:0] bit_timing_one_out,
	output wire [7:0] bit_timing_two_out,
	// can pins
	input  wire       can_rx_pin_in,
	output wire       can_tx_pin_out
);

	localparam integer WAKE_CYCLES_RAW = (WAKE_FILTER_NS + `CMC_CLK_PERIOD_NS - 1)
		/ `CMC_CLK_PERIOD_NS;
	localparam integer WAKE_CYCLES = (WAKE_CYCLES_RAW < 1) ? 1 : WAKE_CYCLES_RAW;
	localparam integer WAKE_LAST_I   = WAKE_CYCLES - 1;
	localparam integer RUN_LAST_I    = `CMC_RECESSIVE_RUN - 1;
	localparam integer BUSOFF_LAST_I = `CMC_BUSOFF_RUNS - 1;
	localparam [15:0]  WAKE_LAST     = WAKE_LAST_I[15:0];
	localparam [3:0]   RUN_LAST      = RUN_LAST_I[3:0];
	localparam [7:0]   BUSOFF_LAST   = BUSOFF_LAST_I[7:0];
	localparam [7:0]   CTL_ONE_RST   = `CMC_RST_CTL_ONE;

	// control and status state
	reg        wait_dis_q;
	reg        synced_q;
	reg        timer_en_q;
	reg        wake_en_q;
	reg        sleep_req_q;
	reg        init_req_q;
	reg        mod_en_q;
	reg        mod_en_done_q;
	reg        clk_sel_q;
	reg        loopback_q;
	reg        listen_q;
	reg        busoff_sel_q;
	reg        wake_filt_q;
	reg        sleep_ack_q;
	reg        init_ack_q;
	reg        wake_flag_q;
	reg        wake_armed_q;
	reg [7:0]  timing_one_q;
	reg [7:0]  timing_two_q;
	reg [7:0]  acc_ctl_q;
	reg [7:0]  id_q [0:FILTER_REGS-1];
	reg [7:0]  mask_q [0:FILTER_REGS-1];
	// pin synchroniser and filters
	reg        rx_s1_q;
	reg        rx_s2_q;
	reg        rx_s3_q;
	reg        rx_lvl_q;
	reg [15:0] wake_cnt_q;
	reg [3:0]  run_cnt_q;
	reg [7:0]  busoff_runs_q;
	reg        user_req_seen_q;

	wire init_active  = init_req_q & init_ack_q;
	wire sleep_active = sleep_req_q & sleep_ack_q;
	wire wr_ctl_one   = reg_wr_in & (reg_addr_in == `CMC_OFS_CTL_ONE);
	wire wr_ctl_two   = reg_wr_in & (reg_addr_in == `CMC_OFS_CTL_TWO) & init_active;
	wire wr_status    = reg_wr_in & (reg_addr_in == `CMC_OFS_STATUS);
	wire wr_locked_ok = reg_wr_in & init_active;

	// wake-up detect: dominant is low; filtered wake needs a long enough pulse
	wire dominant   = ~rx_lvl_q;
	wire wake_hit   = wake_filt_q ? (dominant & (wake_cnt_q >= WAKE_LAST)) : dominant;
	wire wake_event = sleep_active & wake_armed_q & wake_hit;

	// pin protection: recessive is high
	wire tx_forced = cpu_stop_in | (cpu_wait_in & wait_dis_q)
		| init_req_q
		| listen_q
		| ~mod_en_q | sleep_active;
	wire tx_bit    = core_tx_in & ~core_ack_in;

	assign can_tx_pin_out = tx_forced ? 1'b1 : tx_bit;
	// loopback feeds the transmitter stream straight back, ignoring the pin
	assign core_rx_out = loopback_q ? (tx_forced ? 1'b1 : tx_bit) : rx_lvl_q;

	assign module_enable_out          = mod_en_q;
	assign clock_select_out           = clk_sel_q;
	assign listen_only_out            = listen_q;
	assign err_count_freeze_out       = listen_q;
	assign busoff_recovery_select_out = busoff_sel_q;
	assign init_mode_out              = init_active;
	assign sleep_mode_out             = sleep_active;
	assign timer_enable_out           = timer_en_q;
	assign bit_timing_one_out         = timing_one_q;
	assign bit_timing_two_out         = timing_two_q;

	// rx pin: three flops, a change counts once stages two and three agree
	always @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			rx_s1_q  <= 1'b1;
			rx_s2_q  <= 1'b1;
			rx_s3_q  <= 1'b1;
			rx_lvl_q <= 1'b1;
		end else begin
			rx_s1_q <= can_rx_pin_in;
			rx_s2_q <= rx_s1_q;
			rx_s3_q <= rx_s2_q;
			if (rx_s2_q == rx_s3_q) begin
				rx_lvl_q <= rx_s3_q;
			end
		end
	end

	// dominant pulse length for the wake filter
	always @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			wake_cnt_q <= 16'h0000;
		end else if (!dominant || !sleep_active) begin
			wake_cnt_q <= 16'h0000;
		end else if (wake_cnt_q != 16'hffff) begin
			wake_cnt_q <= wake_cnt_q + 16'h0001;
		end
	end

	// first control register and the init / sleep handshakes
	always @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			wait_dis_q   <= CTL_ONE_RST[`CMC_C1_WAIT_DIS];
			timer_en_q   <= 1'b0;
			wake_en_q    <= 1'b0;
			sleep_req_q  <= 1'b0;
			init_req_q   <= 1'b1;
			init_ack_q   <= 1'b1;
			sleep_ack_q  <= 1'b0;
			wake_armed_q <= 1'b0;
			wake_flag_q  <= 1'b0;
		end else begin
			if (wr_ctl_one) begin
				wake_en_q <= reg_wdata_in[`CMC_C1_WAKE_EN];
				if (reg_wdata_in[`CMC_C1_INIT_REQ]) begin
					init_req_q <= 1'b1;
				end else if (init_active) begin
					init_req_q <= 1'b0;
				end
				if (reg_wdata_in[`CMC_C1_SLEEP_REQ]) begin
					if (!wake_flag_q) begin
						sleep_req_q <= 1'b1;
					end
				end else if (sleep_active) begin
					sleep_req_q <= 1'b0;
				end
			end
			// init holds these bits at reset value, wake enable and requests kept
			if (init_active) begin
				wait_dis_q <= 1'b0;
				timer_en_q <= 1'b0;
			end else if (wr_ctl_one) begin
				wait_dis_q <= reg_wdata_in[`CMC_C1_WAIT_DIS];
				timer_en_q <= reg_wdata_in[`CMC_C1_TIMER_EN];
			end
			// acknowledge follows the request one cycle later
			init_ack_q <= init_req_q;
			// sleep ack: set only on an idle bus, dropped with the request
			if (wake_event) begin
				sleep_ack_q <= 1'b0;
				sleep_req_q <= 1'b0;
			end else if (wr_ctl_one && !reg_wdata_in[`CMC_C1_SLEEP_REQ] && sleep_active) begin
				sleep_ack_q <= 1'b0;
			end else if (sleep_req_q && !sleep_ack_q && bus_idle_in && !init_req_q) begin
				sleep_ack_q  <= 1'b1;
				wake_armed_q <= wake_en_q;
			end
			// wake flag: set wins over a write-one clear, held clear in init
			if (init_active) begin
				wake_flag_q <= 1'b0;
			end else if (wake_event) begin
				wake_flag_q <= 1'b1;
			end else if (wr_status && reg_wdata_in[`CMC_ST_WAKE_FLAG]) begin
				wake_flag_q <= 1'b0;
			end
		end
	end

	// second control register, written only in init mode
	always @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			mod_en_q      <= 1'b0;
			mod_en_done_q <= 1'b0;
			clk_sel_q     <= 1'b0;
			loopback_q    <= 1'b0;
			listen_q      <= 1'b0;
			busoff_sel_q  <= 1'b0;
			wake_filt_q   <= 1'b0;
		end else if (wr_ctl_two) begin
			if (special_mode_in || !mod_en_done_q) begin
				mod_en_q      <= reg_wdata_in[`CMC_C2_MOD_EN];
				mod_en_done_q <= 1'b1;
			end
			clk_sel_q    <= reg_wdata_in[`CMC_C2_CLK_SEL];
			loopback_q   <= reg_wdata_in[`CMC_C2_LOOPBACK];
			listen_q     <= reg_wdata_in[`CMC_C2_LISTEN];
			busoff_sel_q <= reg_wdata_in[`CMC_C2_BUSOFF_SEL];
			wake_filt_q  <= reg_wdata_in[`CMC_C2_WAKE_FILT];
		end
	end

	// timing and acceptance control, locked outside init
	always @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			timing_one_q <= `CMC_RST_BYTE;
			timing_two_q <= `CMC_RST_BYTE;
			acc_ctl_q    <= `CMC_RST_BYTE;
		end else if (wr_locked_ok) begin
			if (reg_addr_in == `CMC_OFS_TIMING_ONE) begin
				timing_one_q <= reg_wdata_in;
			end
			if (reg_addr_in == `CMC_OFS_TIMING_TWO) begin
				timing_two_q <= reg_wdata_in;
			end
			if (reg_addr_in == `CMC_OFS_ACC_CTL) begin
				acc_ctl_q <= reg_wdata_in;
			end
		end
	end

	// identifier and mask bytes, locked outside init
	genvar gi;
	generate
		for (gi = 0; gi < FILTER_REGS; gi = gi + 1) begin : g_filter
			localparam integer ID_ADDR   = `CMC_OFS_ID_BASE + gi;
			localparam integer MASK_ADDR = `CMC_OFS_MASK_BASE + gi;
			always @(posedge clk_sys_in) begin
				if (!rst_n_in) begin
					id_q[gi]   <= `CMC_RST_BYTE;
					mask_q[gi] <= `CMC_RST_BYTE;
				end else if (wr_locked_ok) begin
					if (reg_addr_in == ID_ADDR[4:0]) begin
						id_q[gi] <= reg_wdata_in;
					end
					if (reg_addr_in == MASK_ADDR[4:0]) begin
						mask_q[gi] <= reg_wdata_in;
					end
				end
			end
		end
	endgenerate

	// resynchronisation after init: runs of recessive bits
	always @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			run_cnt_q            <= 4'h0;
			busoff_runs_q        <= 8'h00;
			synced_q             <= 1'b0;
			user_req_seen_q      <= 1'b0;
			busoff_recovered_out <= 1'b0;
		end else begin
			busoff_recovered_out <= 1'b0;
			if (busoff_user_req_in) begin
				user_req_seen_q <= 1'b1;
			end
			if (init_req_q || !mod_en_q) begin
				run_cnt_q       <= 4'h0;
				busoff_runs_q   <= 8'h00;
				synced_q        <= 1'b0;
				user_req_seen_q <= 1'b0;
			end else if (bit_tick_in) begin
				if (!core_rx_out) begin
					run_cnt_q <= 4'h0;
				end else if (run_cnt_q == RUN_LAST) begin
					run_cnt_q <= 4'h0;
					if (!busoff_in) begin
						synced_q <= 1'b1;
					end else if (busoff_runs_q == BUSOFF_LAST) begin
						// user-request recovery waits for software's go
						if (!busoff_sel_q || user_req_seen_q) begin
							busoff_recovered_out <= 1'b1;
							busoff_runs_q        <= 8'h00;
							user_req_seen_q      <= 1'b0;
							synced_q             <= 1'b1;
						end
					end else begin
						busoff_runs_q <= busoff_runs_q + 8'h01;
					end
				end else begin
					run_cnt_q <= run_cnt_q + 4'h1;
				end
			end
		end
	end

	// read data one cycle after the strobe; unmapped reads zero
	reg [7:0] rd_d;
	always @* begin
		rd_d = 8'h00;
		case (reg_addr_in)
			`CMC_OFS_CTL_ONE: rd_d = {2'b00, wait_dis_q, synced_q, timer_en_q,
				wake_en_q, sleep_req_q, init_req_q};
			`CMC_OFS_CTL_TWO: rd_d = {mod_en_q, clk_sel_q, loopback_q, listen_q,
				busoff_sel_q, wake_filt_q, sleep_ack_q, init_ack_q};
			`CMC_OFS_TIMING_ONE: rd_d = timing_one_q;
			`CMC_OFS_TIMING_TWO: rd_d = timing_two_q;
			// state fields come straight from the error logic, init leaves them
			`CMC_OFS_STATUS: rd_d = {wake_flag_q, 1'b0, rx_state_field_in,
				tx_state_field_in, 2'b00};
			`CMC_OFS_ACC_CTL: rd_d = acc_ctl_q;
			default: begin
				if (reg_addr_in[4:3] == 2'b10) begin
					rd_d = id_q[reg_addr_in[2:0]];
				end else if (reg_addr_in[4:3] == 2'b11) begin
					rd_d = mask_q[reg_addr_in[2:0]];
				end
			end
		endcase
	end

	always @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_rd_in) begin
			reg_rdata_out <= rd_d;
		end else begin
			reg_rdata_out <= 8'h00;
		end
	end

endmodule // cmc_mode_control

`default_nettype wire

// >>> verilog/cmc_map.vh
// register offsets, field positions, reset values and timing counts
// included by the mode control block; holds definitions only
`ifndef CMC_MAP_VH
`define CMC_MAP_VH

// register offsets (byte addresses on the 8-bit register port)
`define CMC_OFS_CTL_ONE     5'h00
`define CMC_OFS_CTL_TWO     5'h01
`define CMC_OFS_TIMING_ONE  5'h02
`define CMC_OFS_TIMING_TWO  5'h03
`define CMC_OFS_STATUS      5'h04
`define CMC_OFS_ACC_CTL     5'h0b
`define CMC_OFS_ID_BASE     5'h10
`define CMC_OFS_MASK_BASE   5'h18

// first control register fields
`define CMC_C1_WAIT_DIS     5
`define CMC_C1_SYNCED       4
`define CMC_C1_TIMER_EN     3
`define CMC_C1_WAKE_EN      2
`define CMC_C1_SLEEP_REQ    1
`define CMC_C1_INIT_REQ     0

// second control register fields
`define CMC_C2_MOD_EN       7
`define CMC_C2_CLK_SEL      6
`define CMC_C2_LOOPBACK     5
`define CMC_C2_LISTEN       4
`define CMC_C2_BUSOFF_SEL   3
`define CMC_C2_WAKE_FILT    2
`define CMC_C2_SLEEP_ACK    1
`define CMC_C2_INIT_ACK     0

// status register fields
`define CMC_ST_WAKE_FLAG    7
`define CMC_ST_RX_STATE_HI  5
`define CMC_ST_RX_STATE_LO  4
`define CMC_ST_TX_STATE_HI  3
`define CMC_ST_TX_STATE_LO  2

// reset values
`define CMC_RST_CTL_ONE     8'h01
`define CMC_RST_CTL_TWO     8'h01
`define CMC_RST_BYTE        8'h00

// timing
`define CMC_CLK_PERIOD_NS   10
`define CMC_WAKE_FILTER_NS  2000
`define CMC_RECESSIVE_RUN   11
`define CMC_BUSOFF_RUNS     128

`endif

// >>> dv/cmc_bus_node.sv
// can bus node behind a transceiver: wired-and of every driver on the line
// assumes the bench requests dominant pulses; recessive is the idle level
`timescale 1ns/10ps
`default_nettype none
module cmc_bus_node (
	// clock
	input  wire logic       clk_sys_in,
	// bench control
	input  wire logic       dom_go_in,
	input  wire logic [7:0] dom_len_in,
	// bus wires
	input  wire logic       tx_pin_in,
	output logic            rx_pin_out
);
	logic [7:0] dom_cnt_q = 8'h00;
	always @(posedge clk_sys_in) begin
		if (dom_go_in)
			dom_cnt_q <= dom_len_in;
		else if (dom_cnt_q != 8'h00)
			dom_cnt_q <= dom_cnt_q - 8'h01;
	end
	// dominant from any node wins the shared line
	assign rx_pin_out = tx_pin_in & (dom_cnt_q == 8'h00);
endmodule // cmc_bus_node
`default_nettype wire

// >>> dv/cmc_mode_monitor.sv
// port-level checker for the can mode control block
// bound to the design top from the bench top file; single clock domain
`timescale 1ns/10ps
`default_nettype none
module cmc_mode_monitor (
	// clock and reset
	input wire logic       clk_sys_in,
	input wire logic       rst_n_in,
	// register port
	input wire logic [4:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic       reg_wr_in,
	// system and configuration
	input wire logic       cpu_stop_in,
	input wire logic       special_mode_in,
	input wire logic       bus_idle_in,
	input wire logic       module_enable_out,
	input wire logic       clock_select_out,
	input wire logic       listen_only_out,
	input wire logic       err_count_freeze_out,
	input wire logic       busoff_recovery_select_out,
	input wire logic       init_mode_out,
	input wire logic       sleep_mode_out,
	input wire logic [7:0] bit_timing_one_out,
	input wire logic [7:0] bit_timing_two_out,
	input wire logic       can_tx_pin_out
);
	logic clr_init_q;
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	// remembers a cpu write clearing the init request
	always_ff @(posedge clk_sys_in) begin
		clr_init_q <= reg_wr_in && reg_addr_in == 5'h00 && !reg_wdata_in[0];
	end
	sequence s_init_wr;
		reg_wr_in && reg_addr_in == 5'h00 && reg_wdata_in[0] && !init_mode_out;
	endsequence
	sequence s_init_ack;
		can_tx_pin_out ##1 (init_mode_out && can_tx_pin_out);
	endsequence
	stop_tx_a: assert property (cpu_stop_in |-> can_tx_pin_out)
		else $error("tx pin not recessive in stop");
	init_hs_a: assert property (s_init_wr |=> s_init_ack)
		else $error("init request handshake wrong");
	init_exit_a: assert property ($fell(init_mode_out) |-> clr_init_q)
		else $error("init mode left without cpu clear");
	listen_tx_a: assert property (listen_only_out |-> can_tx_pin_out)
		else $error("tx pin driven in listen only");
	listen_frz_a: assert property (listen_only_out |-> err_count_freeze_out)
		else $error("error counters not frozen");
	off_tx_a: assert property (!module_enable_out |-> can_tx_pin_out)
		else $error("disabled module drives tx pin");
	ctl_lock_a: assert property (reg_wr_in && reg_addr_in == 5'h01 && !init_mode_out
		|=> $stable({module_enable_out, clock_select_out, listen_only_out,
		busoff_recovery_select_out})) else $error("second control written outside init");
	tim_lock_a: assert property (reg_wr_in && !init_mode_out &&
		(reg_addr_in == 5'h02 || reg_addr_in == 5'h03)
		|=> $stable({bit_timing_one_out, bit_timing_two_out}))
		else $error("timing written outside init");
	en_once_a: assert property (reg_wr_in && reg_addr_in == 5'h01 && init_mode_out &&
		module_enable_out && !special_mode_in && !reg_wdata_in[7] |=> module_enable_out)
		else $error("module enable rewritten");
	sleep_idle_a: assert property ($rose(sleep_mode_out) |-> $past(bus_idle_in))
		else $error("sleep entered while bus busy");
endmodule // cmc_mode_monitor
`default_nettype wire

// >>> dv/can_mode_control_tb.sv
// bench for the can mode control block: register tasks, handshakes, pin checks
// assumes the bus node model and the bound monitor are compiled beside it
`timescale 1ns/10ps
`default_nettype none
`define CK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
	$display("[FAIL] %s exp %h got %h", n, e, g); end end
module can_mode_control_tb;
	logic       clk, rst_n, wr, rd, stop, wt, spec, idle, ctx, go, ack, boff;
	logic [4:0] addr;
	logic [7:0] wdata, rdata, rv, len;
	logic [1:0] txs, rxs;
	wire        men, csel, lst, frz, bsel, initm, slpm, txp, rxp, crx, brec;
	int         num_errors, checks, wait_n;

	// short filter keeps the long wake pulse brief: 50 cycles
	cmc_mode_control #(.WAKE_FILTER_NS(500)) dut (
		.clk_sys_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .cpu_stop_in(stop),
		.cpu_wait_in(wt), .special_mode_in(spec), .bus_idle_in(idle), .busoff_in(boff),
		.busoff_user_req_in(1'h0), .bit_tick_in(1'h1), .core_tx_in(ctx), .core_ack_in(ack),
		.tx_state_field_in(txs), .rx_state_field_in(rxs), .core_rx_out(crx),
		.busoff_recovered_out(brec), .module_enable_out(men), .clock_select_out(csel),
		.listen_only_out(lst), .err_count_freeze_out(frz),
		.busoff_recovery_select_out(bsel), .init_mode_out(initm), .sleep_mode_out(slpm),
		.timer_enable_out(), .bit_timing_one_out(), .bit_timing_two_out(),
		.can_rx_pin_in(rxp), .can_tx_pin_out(txp));
	cmc_bus_node node (.clk_sys_in(clk), .dom_go_in(go), .dom_len_in(len), .tx_pin_in(txp),
		.rx_pin_out(rxp));

	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	task automatic wreg(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'h1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'h0;
		#1;
	endtask
	task automatic rchk(input string n, input logic [4:0] a, input logic [7:0] e,
		input logic [7:0] m = 8'hff);
		@(posedge clk);
		rd <= 1'h1;
		addr <= a;
		@(posedge clk);
		rd <= 1'h0;
		#1 rv = rdata;
		`CK(n, e, rv & m)
	endtask
	task automatic pause(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// dominant pulse from the far node, then let the line settle
	task automatic dom(input logic [7:0] n);
		@(posedge clk);
		go <= 1'h1;
		len <= n;
		@(posedge clk);
		go <= 1'h0;
		pause(n + 10);
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		#200000;
		num_errors++;
		conclude;
	end

	initial begin
		{rst_n, wr, rd, stop, wt, spec, idle, go, ack, boff} = '0;
		ctx = 1'h1;
		addr = 5'h00;
		wdata = 8'h00;
		len = 8'h00;
		txs = 2'h2;
		rxs = 2'h1;
		repeat (8) @(posedge clk);
		rst_n <= 1'h1;
		rchk("ctl_one", 5'h00, 8'h01);
		rchk("ctl_two", 5'h01, 8'h01);
		rchk("unmapped", 5'h05, 8'h00);
		`CK("tx", 1'h1, txp)
		$display("test reset done");
		wreg(5'h01, 8'h98);
		rchk("ctl_two", 5'h01, 8'h99);
		`CK("en", 1'h1, men)
		`CK("listen", 1'h1, frz & lst)
		`CK("busoff", 1'h1, bsel)
		wreg(5'h01, 8'h64);
		rchk("ctl_two", 5'h01, 8'he5);
		`CK("clk", 1'h1, csel)
		spec <= 1'h1;
		wreg(5'h01, 8'h00);
		`CK("en", 1'h0, men)
		wreg(5'h01, 8'h80);
		spec <= 1'h0;
		wreg(5'h02, 8'h5a);
		wreg(5'h03, 8'ha5);
		rchk("tim1", 5'h02, 8'h5a);
		rchk("tim2", 5'h03, 8'ha5);
		rchk("status", 5'h04, 8'h18);
		$display("test init config done");
		wreg(5'h00, 8'h00);
		rchk("ctl_two", 5'h01, 8'h80);
		wreg(5'h01, 8'h00);
		wreg(5'h02, 8'hff);
		rchk("ctl_two", 5'h01, 8'h80);
		rchk("tim1", 5'h02, 8'h5a);
		pause(20);
		rchk("ctl_one", 5'h00, 8'h10);
		ctx <= 1'h0;
		pause(1);
		`CK("tx", 1'h0, txp)
		stop <= 1'h1;
		pause(1);
		`CK("tx", 1'h1, txp)
		stop <= 1'h0;
		wt <= 1'h1;
		pause(1);
		`CK("tx", 1'h0, txp)
		wreg(5'h00, 8'h20);
		`CK("tx", 1'h1, txp)
		wt <= 1'h0;
		ctx <= 1'h1;
		$display("test tx pin done");
		wreg(5'h00, 8'h06);
		wreg(5'h00, 8'h04);
		rchk("ctl_one", 5'h00, 8'h06, 8'hef);
		`CK("sleep", 1'h0, slpm)
		idle <= 1'h1;
		pause(3);
		`CK("sleep", 1'h1, slpm)
		rchk("ctl_two", 5'h01, 8'h82);
		dom(8'h05);
		`CK("sleep", 1'h0, slpm)
		rchk("ctl_two", 5'h01, 8'h80);
		rchk("status", 5'h04, 8'h98);
		wreg(5'h04, 8'h80);
		wreg(5'h00, 8'h06);
		pause(3);
		wreg(5'h00, 8'h04);
		`CK("sleep", 1'h0, slpm)
		rchk("ctl_two", 5'h01, 8'h80);
		$display("test sleep done");
		// software sleeps first, then requests init while asleep
		wreg(5'h00, 8'h06);
		pause(3);
		// request then clear at once: the clear must be refused
		@(posedge clk);
		wr <= 1'h1;
		addr <= 5'h00;
		wdata <= 8'h07;
		@(posedge clk);
		wdata <= 8'h06;
		@(posedge clk);
		wr <= 1'h0;
		pause(2);
		`CK("init", 1'h1, initm)
		`CK("tx", 1'h1, txp)
		rchk("ctl_one", 5'h00, 8'h07);
		rchk("status", 5'h04, 8'h18);
		wreg(5'h01, 8'ha4);
		wreg(5'h00, 8'h04);
		rchk("ctl_two", 5'h01, 8'ha4);
		// loopback hands the stream back inside; the pin still follows it
		ack <= 1'h1;
		pause(1);
		`CK("loop_rx", 1'h0, crx)
		`CK("tx_ack", 1'h0, txp)
		ack <= 1'h0;
		pause(6);
		`CK("loop_rx", 1'h1, crx)
		wreg(5'h00, 8'h06);
		pause(3);
		dom(8'h0a);
		`CK("sleep", 1'h1, slpm)
		dom(8'h50);
		`CK("sleep", 1'h0, slpm)
		$display("test wake filter done");
		// bus-off: 128 runs of 11 recessive bits, one bit tick per cycle here
		boff <= 1'h1;
		wait_n = 0;
		while (brec !== 1'h1 && wait_n < 1500) begin
			pause(1);
			wait_n++;
		end
		`CK("recover", 1'h1, brec)
		`CK("not_early", 1'h1, wait_n >= 1397)
		boff <= 1'h0;
		$display("test busoff done");
		conclude;
	end
endmodule // can_mode_control_tb

bind cmc_mode_control cmc_mode_monitor u_mon (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
	.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
	.cpu_stop_in(cpu_stop_in), .special_mode_in(special_mode_in), .bus_idle_in(bus_idle_in),
	.module_enable_out(module_enable_out), .clock_select_out(clock_select_out),
	.listen_only_out(listen_only_out), .err_count_freeze_out(err_count_freeze_out),
	.busoff_recovery_select_out(busoff_recovery_select_out), .init_mode_out(init_mode_out),
	.sleep_mode_out(sleep_mode_out), .bit_timing_one_out(bit_timing_one_out),
	.bit_timing_two_out(bit_timing_two_out), .can_tx_pin_out(can_tx_pin_out));
`default_nettype wire
